// ===== rtl/ccf_clock_fanout.sv
// Operation
// - Selected clock is copied identically onto all five outputs.
// - Select low passes source A; select high passes source B.
// - Shared active-low enable: low follows clock, high disables outputs.
// - Enable captured by a flop on the selected clock's falling edge.
// - Enable high forces outputs low from the next falling edge.
// - Gate changes only while the clock is low: no runt pulses.
// - Unconnected select, enable and clock inputs read as low.
module ccf_clock_fanout #(
   parameter int unsigned NUM_OUTPUTS = ccf_pkg::NUM_OUTPUTS
) (
   input  wire logic                   core_clk,        // 40 MHz clock
   input  wire logic                   rst_n,           // Sync reset, low
   input  wire logic                   clock_source_a,  // First clock pin
   input  wire logic                   clock_source_b,  // Second clock pin
   input  wire logic                   clock_select,    // Source select pin
   input  wire logic                   enable_n,        // Enable, active low
   output logic      [NUM_OUTPUTS-1:0] fanout_outputs   // Gated clock copies
);

   ////////////////////////////////////////////////////////////////////////
   // Input filtering

   logic [ccf_pkg::NUM_PINS-1:0] pin_raw;
   logic [ccf_pkg::NUM_PINS-1:0] pin_level;

   // Gather the asynchronous pins into one vector
   always_comb begin
      pin_raw                      = '0;
      pin_raw[ccf_pkg::PIN_SRC_A]  = clock_source_a;
      pin_raw[ccf_pkg::PIN_SRC_B]  = clock_source_b;
      pin_raw[ccf_pkg::PIN_SELECT] = clock_select;
      pin_raw[ccf_pkg::PIN_EN_N]   = enable_n;
   end

   // Three-stage filter; resets low so open pins read low
   ccf_pin_filter #(
      .WIDTH   (ccf_pkg::NUM_PINS),
      .RST_VAL (ccf_pkg::PIN_RST)
   ) u_filter (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .pin_raw   (pin_raw),
      .pin_level (pin_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // Source multiplexer and edge detection

   logic sel_level;
   logic prev_level_q;
   logic prev_level_d;
   logic fall_edge;

   // Pick source A on select low, source B on select high
   always_comb begin
      if (pin_level[ccf_pkg::PIN_SELECT]) begin
         sel_level = pin_level[ccf_pkg::PIN_SRC_B];
      end else begin
         sel_level = pin_level[ccf_pkg::PIN_SRC_A];
      end
   end

   // Falling edge of the selected clock
   always_comb begin
      prev_level_d = sel_level;
      fall_edge    = prev_level_q & ~sel_level;
   end

   // Previous level register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prev_level_q <= ccf_pkg::LEVEL_RST;
      end else begin
         prev_level_q <= prev_level_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronous enable flop

   logic gate_q;
   logic gate_d;

   // Sample the enable only on a falling edge
   always_comb begin
      gate_d = gate_q;
      if (fall_edge) begin
         gate_d = ~pin_level[ccf_pkg::PIN_EN_N];
      end
   end

   // Gate starts closed until the first sample
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gate_q <= ccf_pkg::GATE_RST;
      end else begin
         gate_q <= gate_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output fan-out

   logic [NUM_OUTPUTS-1:0] out_q;
   logic [NUM_OUTPUTS-1:0] out_d;

   // Every output gets the same gated level
   // The gate only moves while the clock is low, so no runts
   genvar go;
   generate
      for (go = 0; go < NUM_OUTPUTS; go++) begin : g_out
         always_comb begin
            out_d[go] = sel_level & gate_d;
         end
      end
   endgenerate

   // Output registers, low from reset
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_q <= ccf_pkg::OUTPUT_RST;
      end else begin
         out_q <= out_d;
      end
   end

   assign fanout_outputs = out_q;

endmodule

// ===== common/ccf_pkg.sv
package ccf_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Sizes

   // Number of identical fan-out outputs
   localparam int unsigned NUM_OUTPUTS = 5;
   // Number of pins that pass the input filter
   localparam int unsigned NUM_PINS    = 4;

   ////////////////////////////////////////////////////////////////////////
   // Positions in the filtered pin vector

   localparam int unsigned PIN_SRC_A  = 0;
   localparam int unsigned PIN_SRC_B  = 1;
   localparam int unsigned PIN_SELECT = 2;
   localparam int unsigned PIN_EN_N   = 3;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset

   // Open pins read low, so every filter stage starts low
   localparam logic [NUM_PINS-1:0]    PIN_RST    = 4'h0;
   // Gate closed until a falling edge has sampled the enable
   localparam logic                   GATE_RST   = 1'b0;
   // Previous selected level starts low: no false falling edge
   localparam logic                   LEVEL_RST  = 1'b0;
   // Outputs held low from reset
   localparam logic [NUM_OUTPUTS-1:0] OUTPUT_RST = 5'h00;

   ////////////////////////////////////////////////////////////////////////
   // Cycle counts

   // Synchroniser stages ahead of the agreement check
   localparam int unsigned SYNC_STAGES = 3;

endpackage

// ===== rtl/ccf_pin_filter.sv
module ccf_pin_filter #(
   parameter int unsigned       WIDTH   = ccf_pkg::NUM_PINS,
   parameter logic [WIDTH-1:0]  RST_VAL = ccf_pkg::PIN_RST
) (
   input  wire logic             core_clk,   // System clock
   input  wire logic             rst_n,      // Sync reset, active low
   input  wire logic [WIDTH-1:0] pin_raw,    // Asynchronous pin levels
   output logic      [WIDTH-1:0] pin_level   // Filtered, registered levels
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s1_d;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s2_d;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] s3_d;
   logic [WIDTH-1:0] lvl_q;
   logic [WIDTH-1:0] lvl_d;

   ////////////////////////////////////////////////////////////////////////
   // Per pin: shift chain, accept a change once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_pin
         always_comb begin
            s1_d[gi] = pin_raw[gi];
            s2_d[gi] = s1_q[gi];
            s3_d[gi] = s2_q[gi];
            if (s2_q[gi] == s3_q[gi]) begin
               lvl_d[gi] = s3_q[gi];
            end else begin
               lvl_d[gi] = lvl_q[gi];
            end
         end
      end
   endgenerate

   // Registers; reset low so an undriven pin reads low
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q  <= s1_d;
         s2_q  <= s2_d;
         s3_q  <= s3_d;
         lvl_q <= lvl_d;
      end
   end

   assign pin_level = lvl_q;

endmodule

// ===== tb/ccf_clock_fanout_assertions.sv
module ccf_clock_fanout_chk #(
   parameter int unsigned NUM_OUTPUTS = 5
) (
   input wire logic                   core_clk,       // System clock
   input wire logic                   rst_n,          // Sync reset, low
   input wire logic                   clock_source_a, // First clock
   input wire logic                   clock_source_b, // Second clock
   input wire logic                   clock_select,   // Source select
   input wire logic                   enable_n,       // Enable, low
   input wire logic [NUM_OUTPUTS-1:0] fanout_outputs  // Gated copies
);
   logic sel; // Selected pin level
   // Mux at the pins, no delay; the checks look back 5 cycles for the design path
   assign sel = clock_select ? clock_source_b : clock_source_a;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_outputs_equal: assert property (&fanout_outputs || ~|fanout_outputs)
      else $error("outputs differ");
   a_high_needs_src: assert property (fanout_outputs[0] |-> $past(sel, 5))
      else $error("output high without source");
   a_rise_from_src: assert property ($rose(fanout_outputs[0])
      |-> $past(sel, 5) && !$past(sel, 6)) else $error("output rise early");
   a_fall_with_src: assert property ($fell(fanout_outputs[0])
      |-> !$past(sel, 5)) else $error("output cut short");
   a_enable_opens: assert property (
      (!enable_n && sel)[*4]
      ##1 (!enable_n && !sel)[*4] ##1 (!enable_n && sel)[*4]
      |-> ##3 fanout_outputs[0]) else $error("output not enabled");
   a_disable_holds: assert property ((enable_n && sel)[*4]
      ##1 (enable_n && !sel)[*4] ##1 enable_n[*8]
      |-> fanout_outputs == '0) else $error("output not disabled");
   a_reset_clears: assert property ($rose(rst_n)
      |-> fanout_outputs == '0 ##1 fanout_outputs == '0)
      else $error("output high after reset");
   a_open_pins_low: assert property (
      (!(clock_source_a || clock_source_b
      || clock_select || enable_n))[*6] |-> fanout_outputs == '0)
      else $error("open pins not low");
   c_rise: cover property ($rose(fanout_outputs[0]));
   c_disable: cover property ($rose(enable_n));
   c_select_b: cover property ($rose(clock_select));
endmodule

bind ccf_clock_fanout ccf_clock_fanout_chk #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .clock_source_a(clock_source_a),
   .clock_source_b(clock_source_b), .clock_select(clock_select),
   .enable_n(enable_n), .fanout_outputs(fanout_outputs));

// ===== tb/ccf_source_model.sv
module ccf_source_model #(
   parameter int HALF_A = 4, // Half period of source A
   parameter int HALF_B = 6  // Half period of source B
) (
   input  wire logic core_clk, // System clock
   input  wire logic run,      // Sources toggle while high
   output logic      src_a,    // First clock source
   output logic      src_b     // Second clock source
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_a = 0;
   int cnt_b = 0;
   logic run_q = 1'b0;
   // Take the run request on the rising edge, clear of the bench's drive
   always @(posedge core_clk) begin
      run_q <= run;
   end
   // Free clocks off the sampling edge, parked low when idle
   always @(negedge core_clk) begin
      cnt_a = run_q ? cnt_a + 1 : 0;
      cnt_b = run_q ? cnt_b + 1 : 0;
      src_a <= !run_q ? 1'b0 : (cnt_a % HALF_A == 0) ? ~src_a : src_a;
      src_b <= !run_q ? 1'b0 : (cnt_b % HALF_B == 0) ? ~src_b : src_b;
   end
endmodule

// ===== tb/ccf_clock_fanout_bench.sv
module ccf_clock_fanout_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk = 1'b0;
   logic       rst_n    = 1'b0;
   logic       sel      = 1'b0;
   logic       en_n     = 1'b0;
   logic       run      = 1'b0;
   logic       src_a;
   logic       src_b;
   logic [4:0] outs;
   int         fail_count = 0;
   int         n_compared = 0;
   always #12.5 core_clk = ~core_clk;
   ccf_source_model #(.HALF_A(4), .HALF_B(6)) u_src (.core_clk(core_clk),
      .run(run), .src_a(src_a), .src_b(src_b));
   ccf_clock_fanout uut (.core_clk(core_clk), .rst_n(rst_n),
      .clock_source_a(src_a), .clock_source_b(src_b), .clock_select(sel),
      .enable_n(en_n), .fanout_outputs(outs));
   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(string what, int exp, int got);
      n_compared++;
      if (exp != got) begin
         fail_count++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // Count rises over a window, checking pulse widths and equal copies
   task automatic sample(int cycles, int half, output int rises);
      logic prev;
      int   width;
      int   bad;
      prev = outs[0];
      width = -1;
      rises = 0;
      bad = 0;
      repeat (cycles) begin
         @(negedge core_clk);
         if (!(outs === 5'h00 || outs === 5'h1f)) bad++;
         if (outs[0] === 1'b1 && prev === 1'b0) begin
            rises++;
            width = 0;
         end
         if (outs[0] === 1'b1 && width >= 0) width++;
         if (outs[0] === 1'b0 && prev === 1'b1 && width >= 0) begin
            check("pulse width", half, width);
            width = -1;
         end
         prev = outs[0];
      end
      check("uneven outputs", 0, bad);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_idle();
      int r;
      sample(20, 4, r);
      check("idle rises", 0, r);
      check("idle level", 1, outs === 5'h00);
   endtask
   task automatic t_follow(logic s, int half, int exp);
      int r;
      sel = s;
      run = 1'b1;
      repeat (16) @(negedge core_clk);
      sample(48, half, r);
      check("follow rises", exp, r);
   endtask
   task automatic t_gate();
      int r;
      en_n = 1'b1;
      sample(48, 6, r);
      sample(48, 6, r);
      check("disabled rises", 0, r);
      en_n = 1'b0;
      sample(48, 6, r);
      sample(48, 6, r);
      check("enabled rises", 4, r);
   endtask
   // Reset in mid-run: outputs low during and just after it
   task automatic t_reset();
      rst_n = 1'b0;
      repeat (4) @(negedge core_clk);
      check("reset level", 1, outs === 5'h00);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      check("post reset level", 1, outs === 5'h00);
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      t_idle();
      t_follow(1'b0, 4, 6);
      t_follow(1'b1, 6, 4);
      t_gate();
      t_reset();
      t_follow(1'b1, 6, 4);
      test_done();
   end
endmodule
